// File: hdl/rrs_exec_pkg.sv
package rrs_exec_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int FADDR_W = 7;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int WATCHDOG_W = 8;
    localparam int PRE_W = 8;
    localparam int MSB_POS = 7;
    localparam int RET_CYCLES = 2;
    localparam logic [DATA_W-1:0] W_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [WATCHDOG_W-1:0] WATCHDOG_CLEAR = 8'h00;
    localparam logic [PRE_W-1:0] PRE_CLEAR = 8'h00;
    localparam logic DEST_W = 1'b0;
    localparam logic DEST_F = 1'b1;
    localparam logic TIMEOUT_RESET = 1'b1;
    localparam logic POWERDOWN_RESET = 1'b1;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_RETURN_WITH_LITERAL,
        OP_RETURN,
        OP_ROTATE_LEFT_CARRY,
        OP_SLEEP,
        OP_CALL
    } op_e;
endpackage

// File: hdl/return_rotate_sleep_exec.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module return_rotate_sleep_exec
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic opValid,
    input wire rrs_exec_pkg::op_e opCode,
    input wire logic [rrs_exec_pkg::DATA_W-1:0] opLiteral,
    input wire logic [rrs_exec_pkg::FADDR_W-1:0] opFileAddr,
    input wire logic opDest,
    input wire logic [rrs_exec_pkg::DATA_W-1:0] fileRdData,
    input wire logic [rrs_exec_pkg::PC_W-1:0] callReturnPc,
    input wire logic watchdogTick,
    input wire logic wakeEvent,
    output logic opReady,
    output logic [rrs_exec_pkg::DATA_W-1:0] accum,
    output logic [rrs_exec_pkg::PC_W-1:0] progCounter,
    output logic carryFlag,
    output logic zeroFlag,
    output logic digitCarryFlag,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic [rrs_exec_pkg::WATCHDOG_W-1:0] watchdog_counter,
    output logic [rrs_exec_pkg::PRE_W-1:0] watchdogPrescaler,
    output logic fileWrEn,
    output logic [rrs_exec_pkg::FADDR_W-1:0] fileWrAddr,
    output logic [rrs_exec_pkg::DATA_W-1:0] fileWrData,
    output logic sleeping,
    output logic [rrs_exec_pkg::SP_W-1:0] stackPtr
);
    import rrs_exec_pkg::*;

    typedef enum logic [1:0] {ST_RUN, ST_SECOND, ST_SLEEP} state_e;

    state_e state_r;
    state_e state_nxt;
    logic [PC_W-1:0] stack_r [STACK_DEPTH];
    logic [DATA_W-1:0] accum_r;
    logic [DATA_W-1:0] accum_nxt;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [SP_W-1:0] sp_r;
    logic [SP_W-1:0] sp_nxt;
    logic carry_r;
    logic zero_r;
    logic dc_r;
    logic timeOut_r;
    logic pwrDown_r;
    logic [WATCHDOG_W-1:0] watchCnt_r;
    logic [WATCHDOG_W-1:0] watchCnt_nxt;
    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_nxt;
    logic ready_r;
    logic sleep_r;
    logic fWrEn_r;
    logic [FADDR_W-1:0] fWrAddr_r;
    logic [DATA_W-1:0] fWrData_r;
    logic wake1_r;
    logic wake2_r;
    logic wake3_r;

    // zero/digit-carry are owned by other instructions; held here only
    wire logic accept = opValid && (state_r == ST_RUN);
    wire logic isRetLit = accept && (opCode == OP_RETURN_WITH_LITERAL);
    wire logic isRet = accept && (opCode == OP_RETURN);
    wire logic isRot = accept && (opCode == OP_ROTATE_LEFT_CARRY);
    wire logic isSleep = accept && (opCode == OP_SLEEP);
    wire logic isCall = accept && (opCode == OP_CALL);
    wire logic isPop = isRetLit || isRet;
    wire logic rotToAccum = isRot && (opDest == DEST_W);
    wire logic rotToFile = isRot && (opDest == DEST_F);
    wire logic stepPc = isCall || isRot || isSleep;
    // pop reads the entry just below the pointer
    wire logic [SP_W-1:0] spPop = sp_r - 3'h1;
    wire logic [SP_W-1:0] spPush = sp_r + 3'h1;
    wire logic [PC_W-1:0] stackTopEntry = stack_r[spPop];
    wire logic [DATA_W-1:0] rotResult = {fileRdData[MSB_POS-1:0], carry_r};
    wire logic rotCarry = fileRdData[MSB_POS];
    // wake counts only once both later sync stages agree
    wire logic wakeSeen = wake2_r && wake3_r;
    wire logic [PC_W-1:0] pcInc = pc_r + 13'h0001;
    wire logic preWrap = (pre_r == 8'hFF);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
            begin
                if (isPop)
                    state_nxt = ST_SECOND;
                else if (isSleep)
                    state_nxt = ST_SLEEP;
            end
            ST_SECOND:
                state_nxt = ST_RUN;
            ST_SLEEP:
            begin
                // core stays halted until an external wake
                if (wakeSeen)
                    state_nxt = ST_RUN;
            end
            default:
                state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= ST_RUN;
        else
            state_r <= state_nxt;
    end

    // wake is asynchronous to the core clock, so it passes three flops
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake1_r <= 1'b0;
            wake2_r <= 1'b0;
            wake3_r <= 1'b0;
        end
        else
        begin
            wake1_r <= wakeEvent;
            wake2_r <= wake1_r;
            wake3_r <= wake2_r;
        end
    end

    // taken from next state so the handshake outputs leave a flop
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_r <= 1'b1;
            sleep_r <= 1'b0;
        end
        else
        begin
            ready_r <= (state_nxt == ST_RUN);
            sleep_r <= (state_nxt == ST_SLEEP);
        end
    end

    // a rotate into the file leaves the accumulator alone
    assign accum_nxt = isRetLit ? opLiteral :
        rotToAccum ? rotResult : accum_r;
    // a taken return overrides any pc step
    assign pc_nxt = isPop ? stackTopEntry :
        stepPc ? pcInc : pc_r;
    assign sp_nxt = isPop ? spPop :
        isCall ? spPush : sp_r;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            accum_r <= W_RESET;
        else
            accum_r <= accum_nxt;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pc_r <= PC_RESET;
        else
            pc_r <= pc_nxt;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sp_r <= '0;
        else
            sp_r <= sp_nxt;
    end

    // stack is a circular buffer, overflow wraps silently
    for (genvar i = 0; i < STACK_DEPTH; i++)
    begin : g_stack
        localparam logic [SP_W-1:0] IDX = SP_W'(i);
        wire logic hit = isCall && (sp_r == IDX);

        always_ff @(posedge sys_clk)
        begin
            if (hit)
                stack_r[i] <= callReturnPc;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            carry_r <= 1'b0;
        else if (isRot)
            carry_r <= rotCarry;
    end

    // other instructions own zero and digit-carry; returns must not touch them
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zero_r <= 1'b0;
            dc_r <= 1'b0;
        end
        else if (isPop)
        begin
            zero_r <= zero_r;
            dc_r <= dc_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            fWrEn_r <= 1'b0;
        else
            fWrEn_r <= rotToFile;
    end

    // address and data follow every op; only the enable qualifies them
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fWrAddr_r <= '0;
            fWrData_r <= '0;
        end
        else
        begin
            fWrAddr_r <= opFileAddr;
            fWrData_r <= rotResult;
        end
    end

    assign pre_nxt = isSleep ? PRE_CLEAR :
        watchdogTick ? pre_r + 8'h01 : pre_r;
    // counter steps only on a prescaler wrap; a sleep clear beats a tick
    assign watchCnt_nxt = isSleep ? WATCHDOG_CLEAR :
        (watchdogTick && preWrap) ? watchCnt_r + 8'h01 : watchCnt_r;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watchCnt_r <= WATCHDOG_CLEAR;
            pre_r <= PRE_CLEAR;
        end
        else
        begin
            watchCnt_r <= watchCnt_nxt;
            pre_r <= pre_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timeOut_r <= TIMEOUT_RESET;
            pwrDown_r <= POWERDOWN_RESET;
        end
        else if (isSleep)
        begin
            pwrDown_r <= 1'b0;
            timeOut_r <= 1'b1;
        end
    end

    assign opReady = ready_r;
    assign accum = accum_r;
    assign progCounter = pc_r;
    assign carryFlag = carry_r;
    assign zeroFlag = zero_r;
    assign digitCarryFlag = dc_r;
    assign timeout_flag = timeOut_r;
    assign powerdown_flag = pwrDown_r;
    assign watchdog_counter = watchCnt_r;
    assign watchdogPrescaler = pre_r;
    assign fileWrEn = fWrEn_r;
    assign fileWrAddr = fWrAddr_r;
    assign fileWrData = fWrData_r;
    assign sleeping = sleep_r;
    assign stackPtr = sp_r;
endmodule

// File: verif/return_rotate_sleep_exec_asserts.sv
`timescale 1ns/10ps
module return_rotate_sleep_exec_asserts
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic opValid,
    input wire rrs_exec_pkg::op_e opCode,
    input wire logic [7:0] opLiteral,
    input wire logic opDest,
    input wire logic [7:0] fileRdData,
    input wire logic opReady,
    input wire logic [7:0] accum,
    input wire logic carryFlag,
    input wire logic zeroFlag,
    input wire logic timeout_flag,
    input wire logic powerdown_flag,
    input wire logic [7:0] watchdog_counter,
    input wire logic [7:0] watchdogPrescaler,
    input wire logic fileWrEn,
    input wire logic [7:0] fileWrData,
    input wire logic sleeping
);
    import rrs_exec_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire tk = opValid && opReady;
    wire rot = tk && opCode == OP_ROTATE_LEFT_CARRY;
    wire slp = tk && opCode == OP_SLEEP;
    wire rw = tk && opCode == OP_RETURN_WITH_LITERAL;
    wire ret = rw || (tk && opCode == OP_RETURN);
    AST_RWL_ACCUM: assert property (rw |=> accum == $past(opLiteral))
        else $error("literal not loaded");
    AST_RET_TWO: assert property (ret |=> !opReady ##1 opReady)
        else $error("return not two cycles");
    AST_RET_FLAGS: assert property (ret |=> $stable(carryFlag) && $stable(zeroFlag))
        else $error("return changed flags");
    AST_ROT_CARRY: assert property (rot |=> carryFlag == $past(fileRdData[7]))
        else $error("rotate carry wrong");
    AST_ROT_ZERO: assert property (rot |=> $stable(zeroFlag))
        else $error("rotate changed zero");
    AST_ROT_ACC: assert property (rot && opDest == DEST_W |=> !fileWrEn
        && accum == {$past(fileRdData[6:0]), $past(carryFlag)}) else $error("rotate to accum");
    AST_ROT_FILE: assert property (rot && opDest == DEST_F |=> fileWrEn && $stable(accum)
        && fileWrData == {$past(fileRdData[6:0]), $past(carryFlag)}) else $error("rotate to file");
    AST_SLP_FLAGS: assert property (slp |=> !powerdown_flag && timeout_flag)
        else $error("sleep flags wrong");
    AST_SLP_WATCHDOG: assert property (slp |=> watchdog_counter == 8'h00
        && watchdogPrescaler == 8'h00)
        else $error("watchdog not cleared");
    AST_HALT: assert property (slp |=> sleeping && !opReady)
        else $error("no halt after sleep");
    cover property (ret);
    cover property (rot && opDest == DEST_F);
    cover property (slp ##1 sleeping [*3]);
endmodule
bind return_rotate_sleep_exec return_rotate_sleep_exec_asserts chk (.sys_clk, .rst_n, .opValid,
    .opCode, .opLiteral, .opDest, .fileRdData, .opReady, .accum, .carryFlag, .zeroFlag,
    .timeout_flag, .powerdown_flag, .watchdog_counter, .watchdogPrescaler, .fileWrEn, .fileWrData,
    .sleeping);

// File: verif/test_return_rotate_sleep_exec.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module test_return_rotate_sleep_exec;
    import rrs_exec_pkg::*;
    logic sys_clk, rst_n, opValid, opDest, watchdogTick, wakeEvent, digitCarryFlag;
    op_e opCode;
    logic [7:0] opLiteral, fileRdData, accum, fileWrData, watchdog_counter, watchdogPrescaler;
    logic [6:0] opFileAddr, fileWrAddr;
    logic [2:0] stackPtr;
    logic [12:0] callReturnPc, progCounter;
    logic opReady, carryFlag, zeroFlag, timeout_flag, powerdown_flag, fileWrEn, sleeping;
    int errors = 0;
    int check_count = 0;
    return_rotate_sleep_exec uut (.sys_clk, .rst_n, .opValid, .opCode, .opLiteral, .opFileAddr,
        .opDest, .fileRdData, .callReturnPc, .watchdogTick, .wakeEvent, .opReady, .accum,
        .progCounter, .carryFlag, .zeroFlag, .digitCarryFlag, .timeout_flag, .powerdown_flag,
        .watchdog_counter, .watchdogPrescaler, .fileWrEn, .fileWrAddr, .fileWrData, .sleeping,
        .stackPtr);
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // offered for one edge, then checked once that edge's updates have landed
    task issue(input op_e c, input logic [7:0] k, input logic d, input logic [7:0] f);
        opValid <= 1'b1;
        opCode <= c;
        opLiteral <= k;
        opDest <= d;
        fileRdData <= f;
        opFileAddr <= 7'h7F;
        @(posedge sys_clk);
        opValid <= 1'b0;
        #1;
    endtask
    task t_rotate;
        issue(OP_ROTATE_LEFT_CARRY, 8'h00, DEST_W, 8'hE6);
        `CHK(accum, 8'hCC)
        `CHK(carryFlag, 1'b1)
        `CHK(fileWrEn, 1'b0)
        issue(OP_ROTATE_LEFT_CARRY, 8'h00, DEST_F, 8'h81);
        `CHK(fileWrEn, 1'b1)
        `CHK(fileWrData, 8'h03)
        `CHK(fileWrAddr, 7'h7F)
        `CHK(accum, 8'hCC)
        `CHK(carryFlag, 1'b1)
        `CHK(zeroFlag, 1'b0)
    endtask
    task t_returns;
        callReturnPc <= 13'h0ABC;
        issue(OP_CALL, 8'h00, DEST_W, 8'h00);
        callReturnPc <= 13'h1FFF;
        issue(OP_CALL, 8'h00, DEST_W, 8'h00);
        issue(OP_RETURN_WITH_LITERAL, 8'hFF, DEST_W, 8'h00);
        `CHK(accum, 8'hFF)
        `CHK(progCounter, 13'h1FFF)
        `CHK(opReady, 1'b0)
        `CHK(carryFlag, 1'b1)
        `CHK(stackPtr, 3'h1)
        // second cycle of the return refuses any op
        @(posedge sys_clk);
        issue(OP_RETURN, 8'h00, DEST_W, 8'h00);
        `CHK(progCounter, 13'h0ABC)
        `CHK(stackPtr, 3'h0)
        `CHK(digitCarryFlag, 1'b0)
        `CHK(opReady, 1'b0)
        `CHK(carryFlag, 1'b1)
        `CHK(zeroFlag, 1'b0)
    endtask
    task t_sleep;
        int n;
        watchdogTick <= 1'b1;
        repeat (257) @(posedge sys_clk);
        watchdogTick <= 1'b0;
        #1;
        `CHK(watchdog_counter, 8'h01)
        `CHK(watchdogPrescaler, 8'h01)
        `CHK(powerdown_flag, 1'b1)
        issue(OP_SLEEP, 8'h00, DEST_W, 8'h00);
        `CHK(powerdown_flag, 1'b0)
        `CHK(timeout_flag, 1'b1)
        `CHK(watchdog_counter, 8'h00)
        `CHK(watchdogPrescaler, 8'h00)
        `CHK(sleeping, 1'b1)
        // a halted core must not take this
        issue(OP_RETURN_WITH_LITERAL, 8'h5A, DEST_W, 8'h00);
        `CHK(accum, 8'hFF)
        wakeEvent <= 1'b1;
        n = 0;
        while (opReady !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        wakeEvent <= 1'b0;
        `CHK(opReady, 1'b1)
    endtask
    task conclude;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #5000;
        errors++;
        conclude;
    end
    initial
    begin
        rst_n = 1'b0;
        opValid = 1'b0;
        opCode = OP_NONE;
        opLiteral = 8'h00;
        opFileAddr = 7'h00;
        opDest = 1'b0;
        fileRdData = 8'h00;
        callReturnPc = 13'h0000;
        watchdogTick = 1'b0;
        wakeEvent = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_rotate;
        t_returns;
        t_sleep;
        conclude;
    end
endmodule
